// [core/ccmd_decrypt_verify.sv]
// ccmd_decrypt_verify: decrypts a received frame and checks its tag before release.
// assumes an external block cipher with a request/response port and one clock.
// Summary of operation
// - Split input into ciphertext and M-octet tag.
// - Zero-pad ciphertext to a multiple of sixteen.
// - Reuse counter-mode keystream on blocks and tag.
// - Keystream output gives plaintext then candidate tag.
// - Format associated data and plaintext as forward.
// - Recompute tag with CBC-MAC over formatted input.
// - Valid only when both tags are identical.
// - Mark data rejected on failure, else accepted.
// - After failure destroy plaintext, show only failure.
// - Zero-length tag means decryption only.
// - Counter blocks differ from the first MAC block unless tag and associated data are both empty.
// - Counter block: flags, nonce, block index.
// - First MAC block: flags, nonce, message length.
// - Length prefix chosen by associated data size.
// - Block zero keystream masks tag; data from one.
module ccmd_decrypt_verify
	import ccmd_pkg::*;
(
	input  wire logic                         clk_sys,       // system clock, 250 MHz
	input  wire logic                         reset,         // synchronous, active high
	input  wire logic                         start,         // pulse: new message
	input  wire logic [ccmd_pkg::NONCE_W-1:0] nonce,         // nonce, taken with start
	input  wire logic [4:0]                   m_len,         // tag octets, taken with start
	input  wire logic [63:0]                  a_len,         // associated data octets
	input  wire logic [15:0]                  c_len,         // received octets incl. tag
	output logic                              busy,          // message in progress
	input  wire logic                         ad_valid,      // associated data octet offered
	input  wire logic [7:0]                   ad_data,       // associated data octet
	output logic                              ad_ready,      // associated data octet taken
	input  wire logic                         ct_valid,      // received octet offered
	input  wire logic [7:0]                   ct_data,       // received octet
	output logic                              ct_ready,      // received octet taken
	output logic                              pt_valid,      // plaintext block offered
	output logic      [ccmd_pkg::BLK_W-1:0]   pt_data,       // plaintext block, octet 0 on top
	output logic      [4:0]                   pt_octets,     // real octets in block
	output logic                              pt_last,       // last block of message
	input  wire logic                         pt_ready,      // plaintext block taken
	output logic                              aes_req_valid, // cipher request
	output logic      [ccmd_pkg::BLK_W-1:0]   aes_req_blk,   // cipher input block
	input  wire logic                         aes_req_ready, // cipher takes request
	input  wire logic                         aes_rsp_valid, // cipher result pulse
	input  wire logic [ccmd_pkg::BLK_W-1:0]   aes_rsp_blk,   // cipher result
	output logic                              ok_pulse,      // pulse: message valid
	output logic                              fail_pulse     // pulse: message invalid
);

	import ccmd_pkg::*;

	ccmd_state_e        state;
	ccmd_state_e        ret;
	ccmd_dst_e          dst;
	logic [NONCE_W-1:0] nonce_q;
	logic [4:0]         m_q;
	logic [63:0]        a_q;
	logic [63:0]        ad_rem;
	logic [15:0]        p_len;
	logic [15:0]        ct_rem;
	logic [15:0]        idx;
	logic [BLK_W-1:0]   s0;
	logic [BLK_W-1:0]   x;
	logic [BLK_W-1:0]   ks;
	logic [BLK_W-1:0]   blk;
	logic [4:0]         cnt;
	logic [4:0]         nv;
	logic [PREF_W-1:0]  pref_q;
	logic [3:0]         pref_n;
	logic               release_q;
	logic [BLK_W-1:0]   ctr_blk;
	logic [BLK_W-1:0]   b0_blk;
	logic [PREF_W-1:0]  fmt_pref;
	logic [3:0]         fmt_pref_n;

	ccmd_blkfmt u_fmt (
		.nonce   (nonce_q),
		.m_len   (m_q),
		.a_len   (a_q),
		.p_len   (p_len),
		.idx     (idx),
		.ctr_blk (ctr_blk),
		.b0_blk  (b0_blk),
		.pref    (fmt_pref),
		.pref_n  (fmt_pref_n)
	);

	// checks on the frame shape made when a message starts
	logic        m_ok;
	logic        too_short;
	logic [15:0] body_len;
	logic        start_bad;
	assign m_ok      = (m_len == 5'h00) | (~m_len[0] & (m_len >= 5'h04) & (m_len <= 5'h10));
	assign too_short = c_len < {11'h000, m_len};
	assign body_len  = c_len - {11'h000, m_len};
	assign start_bad = ~m_ok | too_short | (body_len > MAX_P_OCT);
	assign busy      = (state != ST_IDLE);

	// octet gathering: prefix first, then associated data, then zero padding
	logic       in_ad;
	logic       src_pref;
	logic       ad_exh;
	logic       ad_take;
	logic       ct_take;
	logic       step;
	logic       blk_full;
	logic [7:0] oct;
	logic [BLK_W-1:0] next_blk;
	assign in_ad    = (state == ST_AD);
	assign src_pref = (pref_n != 4'h0);
	assign ad_exh   = ~src_pref & (ad_rem == 64'h0);
	assign ad_ready = in_ad & ~src_pref & (ad_rem != 64'h0);
	assign ad_take  = ad_ready & ad_valid;
	assign ct_ready = ((state == ST_CT) & (ct_rem != 16'h0)) |
	                  ((state == ST_TAG) & (cnt < m_q));
	assign ct_take  = ct_ready & ct_valid;
	assign step     = (in_ad & (src_pref | ad_take | (ad_exh & (cnt != 5'h00)))) |
	                  ((state == ST_CT) & (ct_take | ((ct_rem == 16'h0) & (cnt != 5'h00)))) |
	                  ((state == ST_TAG) & ct_take);
	assign oct      = in_ad ? (src_pref ? pref_q[PREF_W-1 -: 8] : (ad_take ? ad_data : 8'h00)) :
	                  (ct_take ? ct_data : 8'h00);
	assign next_blk = {blk[BLK_W-9:0], oct};
	assign blk_full = step & (cnt == 5'h0F) & (state != ST_TAG);

	// plaintext block: pad octets forced to zero so the MAC sees the padded plaintext
	logic [BLK_W-1:0] pmask;
	logic [BLK_W-1:0] p_blk;
	assign pmask = ~({BLK_W{1'b1}} >> {nv, 3'b000});
	assign p_blk = (blk ^ ks) & pmask;

	// tag check: received tag sits right aligned in blk, moved to the left edge
	logic [BLK_W-1:0] u_al;
	logic [BLK_W-1:0] tmask;
	logic             tag_ok;
	assign u_al   = blk << {5'h10 - m_q, 3'b000};
	assign tmask  = ~({BLK_W{1'b1}} >> {m_q, 3'b000});
	assign tag_ok = (((u_al ^ s0) ^ x) & tmask) == '0;

	// plaintext buffer; nothing leaves before the verdict, so frames are capped at its size
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic flush;
	logic [PT_W-1:0] fifo_out;
	assign flush    = (state == ST_CHECK) & ~tag_ok;
	assign pt_valid = fifo_out_valid & release_q;
	// buffer words stay in the flops after a flush, so the outputs show zero unless released
	assign pt_data  = fifo_out[PT_W-1 -: BLK_W] & {BLK_W{pt_valid}};
	assign pt_octets = fifo_out[5:1] & {5{pt_valid}};
	assign pt_last  = fifo_out[0] & pt_valid;

	ccmd_fifo #(
		.W (PT_W),
		.D (FIFO_DEPTH)
	) u_fifo (
		.clk_sys   (clk_sys),
		.reset     (reset),
		.flush     (flush),
		.in_valid  (state == ST_PUSH),
		.in_ready  (fifo_in_ready),
		.in_data   ({p_blk, nv, (ct_rem == 16'h0)}),
		.out_valid (fifo_out_valid),
		.out_ready (pt_ready & release_q),
		.out_data  (fifo_out)
	);

	// gatherer registers
	always_ff @(posedge clk_sys) begin
		if (reset || state == ST_CHECK) begin
			blk <= '0;
		end else if (step) begin
			blk <= next_blk;
		end
	end

	// controller; the cipher port carries one request at a time
	always_ff @(posedge clk_sys) begin
		if (reset) begin
			state <= ST_IDLE;
			ret <= ST_IDLE;
			dst <= DST_X;
			aes_req_valid <= 1'b0;
			aes_req_blk <= '0;
			ok_pulse <= 1'b0;
			fail_pulse <= 1'b0;
			release_q <= 1'b0;
			nonce_q <= '0;
			m_q <= 5'h00;
			a_q <= 64'h0;
			p_len <= 16'h0;
			ad_rem <= 64'h0;
			ct_rem <= 16'h0;
			idx <= 16'h0;
			cnt <= 5'h00;
			nv <= 5'h00;
			pref_q <= '0;
			pref_n <= 4'h0;
			s0 <= '0;
			x <= '0;
			ks <= '0;
		end else begin
			ok_pulse <= 1'b0;
			fail_pulse <= 1'b0;
			if (aes_req_valid && aes_req_ready)
				aes_req_valid <= 1'b0;
			if (step) begin
				cnt <= cnt + 5'h01;
				if (ad_take)
					ad_rem <= ad_rem - 64'h1;
				if (in_ad && src_pref) begin
					pref_q <= {pref_q[PREF_W-9:0], 8'h00};
					pref_n <= pref_n - 4'h1;
				end
				if (state == ST_CT && ct_take) begin
					ct_rem <= ct_rem - 16'h1;
					nv <= nv + 5'h01;
				end
			end
			case (state)
				ST_IDLE: begin
					if (start) begin
						nonce_q <= nonce;
						m_q <= m_len;
						a_q <= a_len;
						p_len <= body_len;
						ct_rem <= body_len;
						idx <= 16'h0;
						cnt <= 5'h00;
						nv <= 5'h00;
						if (start_bad)
							fail_pulse <= 1'b1;
						else
							state <= ST_S0;
					end
				end
				ST_S0: begin
					pref_q <= fmt_pref;
					pref_n <= fmt_pref_n;
					ad_rem <= a_q;
					aes_req_valid <= 1'b1;
					aes_req_blk <= ctr_blk;
					dst <= DST_S0;
					ret <= ST_MAC0;
					state <= ST_WAIT;
				end
				ST_MAC0: begin
					aes_req_valid <= 1'b1;
					aes_req_blk <= b0_blk;
					dst <= DST_X;
					ret <= ST_AD;
					state <= ST_WAIT;
				end
				ST_AD: begin
					if (cnt == 5'h00 && ad_exh) begin
						state <= ST_CT;
					end else if (blk_full) begin
						aes_req_valid <= 1'b1;
						aes_req_blk <= x ^ next_blk;
						dst <= DST_X;
						ret <= ST_AD;
						cnt <= 5'h00;
						state <= ST_WAIT;
					end
				end
				ST_CT: begin
					if (cnt == 5'h00 && ct_rem == 16'h0) begin
						state <= ST_TAG;
					end else if (blk_full) begin
						idx <= idx + 16'h1;
						cnt <= 5'h00;
						state <= ST_KEY;
					end
				end
				ST_KEY: begin
					aes_req_valid <= 1'b1;
					aes_req_blk <= ctr_blk;
					dst <= DST_KS;
					ret <= ST_PUSH;
					state <= ST_WAIT;
				end
				ST_PUSH: begin
					if (fifo_in_ready) begin
						aes_req_valid <= 1'b1;
						aes_req_blk <= x ^ p_blk;
						dst <= DST_X;
						ret <= ST_CT;
						nv <= 5'h00;
						state <= ST_WAIT;
					end
				end
				ST_TAG: begin
					if (cnt == m_q)
						state <= ST_CHECK;
				end
				ST_CHECK: begin
					ok_pulse <= tag_ok;
					fail_pulse <= ~tag_ok;
					release_q <= tag_ok;
					ks <= '0;
					x <= '0;
					state <= tag_ok ? ST_DRAIN : ST_IDLE;
				end
				ST_DRAIN: begin
					if (!fifo_out_valid) begin
						release_q <= 1'b0;
						state <= ST_IDLE;
					end
				end
				ST_WAIT: begin
					if (aes_rsp_valid) begin
						case (dst)
							DST_S0:  s0 <= aes_rsp_blk;
							DST_KS:  ks <= aes_rsp_blk;
							default: x <= aes_rsp_blk;
						endcase
						state <= ret;
					end
				end
				default: state <= ST_IDLE;
			endcase
		end
	end

	property p_short_invalid;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_IDLE && start && too_short) |=> (fail_pulse && !ok_pulse && state == ST_IDLE);
	endproperty
	a_short_invalid: assert property (p_short_invalid) else $error("short frame not refused");

	property p_ctr_flags;
		@(posedge clk_sys) disable iff (reset)
		(aes_req_valid && dst != DST_X) |-> (aes_req_blk[127:120] == CTR_FLAGS);
	endproperty
	a_ctr_flags: assert property (p_ctr_flags) else $error("counter block flags wrong");

	property p_b0_mfield;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_MAC0 && m_q != 5'h00) |=> (aes_req_blk[125:123] != 3'h0 && aes_req_blk[122:120] == L_FIELD);
	endproperty
	a_b0_mfield: assert property (p_b0_mfield) else $error("first MAC block flags wrong");

	property p_pref_short;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_S0 && a_q != 64'h0 && a_q < AD_SHORT) |=> (pref_n == 4'h2 && pref_q[63:0] == 64'h0);
	endproperty
	a_pref_short: assert property (p_pref_short) else $error("short prefix size wrong");

	property p_verdict_pulse;
		@(posedge clk_sys) disable iff (reset)
		(ok_pulse || fail_pulse) |-> !(ok_pulse && fail_pulse) ##1 !(ok_pulse || fail_pulse);
	endproperty
	a_verdict_pulse: assert property (p_verdict_pulse) else $error("verdict not a single pulse");

	property p_no_leak;
		@(posedge clk_sys) disable iff (reset)
		fail_pulse |-> (!pt_valid && pt_data == '0)[*4];
	endproperty
	a_no_leak: assert property (p_no_leak) else $error("plaintext shown after failure");

	property p_zero_tag;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_CHECK && m_q == 5'h00) |=> (ok_pulse && release_q);
	endproperty
	a_zero_tag: assert property (p_zero_tag) else $error("zero tag not accepted");

	property p_tag_mismatch;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_TAG && cnt == m_q && m_q != 5'h00) ##1 (((u_al ^ s0 ^ x) & tmask) != '0) |=> fail_pulse;
	endproperty
	a_tag_mismatch: assert property (p_tag_mismatch) else $error("tag mismatch not refused");

	property p_ctr_idx;
		@(posedge clk_sys) disable iff (reset)
		(state == ST_KEY) |=> (aes_req_blk[15:0] == idx && idx != 16'h0 && aes_req_valid);
	endproperty
	a_ctr_idx: assert property (p_ctr_idx) else $error("data counter index wrong");

endmodule

// [core/ccmd_pkg.sv]
// ccmd_pkg: shared constants and types of the decrypt-and-verify block.
// assumes a 128-bit block cipher outside the block and a length field of two octets.
package ccmd_pkg;

	localparam int          L_OCT      = 2;                 // octets of the message length field
	localparam int          NONCE_W    = 8 * (15 - L_OCT);  // nonce bits
	localparam int          BLK_W      = 128;               // cipher block bits
	localparam int          PREF_W     = 80;                // longest length prefix, ten octets
	localparam int          FIFO_DEPTH = 16;                // plaintext blocks held until verdict
	localparam int          PT_W       = BLK_W + 5 + 1;     // block, octet count, last flag
	localparam logic [15:0] MAX_P_OCT  = 16'h0100;          // plaintext octets that fit the buffer
	localparam logic [2:0]  L_FIELD    = 3'(L_OCT - 1);     // encoding of L minus one
	localparam logic [7:0]  CTR_FLAGS  = {5'h00, L_FIELD};  // reserved, zero tag field, L
	localparam logic [63:0] AD_SHORT   = 64'h0000_0000_0000_FF00; // below this a two-octet prefix
	localparam logic [63:0] AD_MID     = 64'h0000_0001_0000_0000; // below this a six-octet prefix
	localparam logic [7:0]  PREF_ESC   = 8'hFF;             // first escape octet
	localparam logic [7:0]  PREF_MID   = 8'hFE;             // second octet, 32-bit length
	localparam logic [7:0]  PREF_LONG  = 8'hFF;             // second octet, 64-bit length

	typedef enum logic [10:0] {
		ST_IDLE  = 11'h001,
		ST_S0    = 11'h002,
		ST_MAC0  = 11'h004,
		ST_AD    = 11'h008,
		ST_CT    = 11'h010,
		ST_KEY   = 11'h020,
		ST_PUSH  = 11'h040,
		ST_TAG   = 11'h080,
		ST_CHECK = 11'h100,
		ST_DRAIN = 11'h200,
		ST_WAIT  = 11'h400
	} ccmd_state_e;

	typedef enum logic [1:0] {
		DST_X  = 2'h0,
		DST_S0 = 2'h1,
		DST_KS = 2'h2
	} ccmd_dst_e;

endpackage

// [core/ccmd_fifo.sv]
// ccmd_fifo: flip-flop FIFO with valid/ready on both sides and a flush.
// assumes one clock; flush wins over a push in the same cycle.
module ccmd_fifo #(
	parameter int W = 8,
	parameter int D = 16
) (
	input  wire logic         clk_sys,   // system clock
	input  wire logic         reset,     // synchronous, active high
	input  wire logic         flush,     // empty the FIFO at once
	input  wire logic         in_valid,  // write side offers a word
	output logic              in_ready,  // space is free
	input  wire logic [W-1:0] in_data,   // word to store
	output logic              out_valid, // a word is held
	input  wire logic         out_ready, // read side takes the word
	output logic      [W-1:0] out_data   // oldest word
);

	localparam int AW = $clog2(D);

	logic [W-1:0]         mem [D];
	logic [AW-1:0]        wr_ptr;
	logic [AW-1:0]        rd_ptr;
	logic [$clog2(D+1)-1:0] count;
	logic                 push;
	logic                 pop;

	// honest flags straight from the occupancy count
	assign in_ready  = (count != ($clog2(D+1))'(D));
	assign out_valid = (count != '0);
	assign push      = in_valid & in_ready;
	assign pop       = out_valid & out_ready;
	assign out_data  = mem[rd_ptr];

	// storage is written only, never reset, to keep the array plain
	always_ff @(posedge clk_sys) begin
		if (push)
			mem[wr_ptr] <= in_data;
	end

	// pointers and count; flush drops everything, including this cycle's push
	always_ff @(posedge clk_sys) begin
		if (reset || flush) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count  <= '0;
		end else begin
			if (push)
				wr_ptr <= wr_ptr + AW'(1);
			if (pop)
				rd_ptr <= rd_ptr + AW'(1);
			count <= count + ($clog2(D+1))'(push) - ($clog2(D+1))'(pop);
		end
	end

endmodule

// [core/ccmd_blkfmt.sv]
// ccmd_blkfmt: builds counter blocks, the first MAC block and the length prefix.
// assumes registered inputs from the controller; purely combinational.
module ccmd_blkfmt
	import ccmd_pkg::*;
(
	input  wire logic [NONCE_W-1:0] nonce,    // nonce of the message
	input  wire logic [4:0]         m_len,    // tag length in octets
	input  wire logic [63:0]        a_len,    // associated data length
	input  wire logic [15:0]        p_len,    // plaintext length
	input  wire logic [15:0]        idx,      // counter index
	output logic      [BLK_W-1:0]   ctr_blk,  // counter block for idx
	output logic      [BLK_W-1:0]   b0_blk,   // first MAC block
	output logic      [PREF_W-1:0]  pref,     // length prefix, left aligned
	output logic      [3:0]         pref_n    // prefix octets
);

	logic [2:0] m_field;
	logic [7:0] b0_flags;

	// counter blocks keep the tag field zero, so they equal a first MAC block only when m_len and a_len are both zero
	assign ctr_blk  = {CTR_FLAGS, nonce, idx};
	assign m_field  = (m_len == 5'h00) ? 3'h0 : 3'((m_len - 5'h02) >> 1);
	assign b0_flags = {1'b0, (a_len != 64'h0), m_field, L_FIELD};
	assign b0_blk   = {b0_flags, nonce, p_len};

	// prefix size grows with the associated data length
	assign pref   = (a_len == 64'h0) ? '0 :
	                (a_len < AD_SHORT) ? {a_len[15:0], 64'h0} :
	                (a_len < AD_MID) ? {PREF_ESC, PREF_MID, a_len[31:0], 32'h0000_0000} :
	                {PREF_ESC, PREF_LONG, a_len};
	assign pref_n = (a_len == 64'h0) ? 4'h0 :
	                (a_len < AD_SHORT) ? 4'h2 :
	                (a_len < AD_MID) ? 4'h6 : 4'hA;

endmodule

// [verif/ccmd_cipher_model.sv]
// ccmd_cipher_model: toy keyed block cipher that stands at the block's cipher port.
// assumes one clock; takes one request at a time and answers after a random delay.
module ccmd_cipher_model (
	input  wire logic         clk_sys,   // system clock
	input  wire logic         reset,     // synchronous, active high
	input  wire logic         req_valid, // request from the block
	input  wire logic [127:0] req_blk,   // block to encrypt
	output logic              req_ready, // request accepted
	output logic              rsp_valid, // result pulse
	output logic      [127:0] rsp_blk    // result
);
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [127:0] KEY = 128'h0F1E_2D3C_4B5A_6978_8796_A5B4_C3D2_E1F0; // arbitrary key
	logic         pend;
	logic [127:0] res;
	int           cnt;

	// not a real cipher: a keyed mix is enough to expose a wrong block or a wrong order
	function automatic logic [127:0] enc(input logic [127:0] x);
		return ((x ^ KEY) * 128'h9E37_79B9_7F4A_7C15_F39C_C060_5CED_C835) ^ {x[62:0], x[127:63]};
	endfunction

	// idle result lines toggle, so a block that reads them outside the pulse sees junk
	always @(posedge clk_sys) begin
		if (reset) begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			pend      <= 1'b0;
			cnt       <= 0;
			rsp_blk   <= '0;
		end else begin
			rsp_valid <= 1'b0;
			rsp_blk   <= ~rsp_blk;
			if (req_valid && req_ready) begin
				pend      <= 1'b1;
				res       <= enc(req_blk); // one call per request; runs stay far below the per-key limit
				cnt       <= 1 + $urandom % 6;
				req_ready <= 1'b0;
			end else if (pend) begin
				cnt <= cnt - 1;
				if (cnt == 1) begin
					rsp_valid <= 1'b1;
					rsp_blk   <= res;
					pend      <= 1'b0;
				end
			end else begin
				req_ready <= 1'($urandom % 2);
			end
		end
	end
endmodule

// [verif/tb_ccm_star_decrypt_verify.sv]
// tb_ccm_star_decrypt_verify: drives whole frames and compares verdicts and plaintext with a queue model.
// assumes the cipher model above; every wait is bounded and ends the run when it expires.
module tb_ccm_star_decrypt_verify;
	timeunit 1ns;
	timeprecision 100ps;
	import ccmd_pkg::*;
	logic               clk_sys = 0, reset = 1, start = 0, ad_valid = 0, ct_valid = 0, pt_ready = 0;
	logic [NONCE_W-1:0] nonce = '0;
	logic [4:0]         m_len = '0, pt_octets;
	logic [63:0]        a_len = '0;
	logic [15:0]        c_len = '0;
	logic [7:0]         ad_data = '0, ct_data = '0;
	logic               busy, ad_ready, ct_ready, pt_valid, pt_last, ok_pulse, fail_pulse;
	logic               aes_req_valid, aes_req_ready, aes_rsp_valid;
	logic [BLK_W-1:0]   pt_data, aes_req_blk, aes_rsp_blk;
	int                 errors = 0, checked = 0, k;

	ccmd_decrypt_verify u_dut (.clk_sys(clk_sys), .reset(reset), .start(start), .nonce(nonce),
		.m_len(m_len), .a_len(a_len), .c_len(c_len), .busy(busy), .ad_valid(ad_valid),
		.ad_data(ad_data), .ad_ready(ad_ready), .ct_valid(ct_valid), .ct_data(ct_data),
		.ct_ready(ct_ready), .pt_valid(pt_valid), .pt_data(pt_data), .pt_octets(pt_octets),
		.pt_last(pt_last), .pt_ready(pt_ready), .aes_req_valid(aes_req_valid),
		.aes_req_blk(aes_req_blk), .aes_req_ready(aes_req_ready), .aes_rsp_valid(aes_rsp_valid),
		.aes_rsp_blk(aes_rsp_blk), .ok_pulse(ok_pulse), .fail_pulse(fail_pulse));
	ccmd_cipher_model u_cip (.clk_sys(clk_sys), .reset(reset), .req_valid(aes_req_valid),
		.req_blk(aes_req_blk), .req_ready(aes_req_ready), .rsp_valid(aes_rsp_valid),
		.rsp_blk(aes_rsp_blk));

	always #2 clk_sys = ~clk_sys;

	task automatic stop_test;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk_bit(input string what, input logic e, input logic g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %b seen %b", what, e, g);
		end
	endtask

	task automatic chk_blk(input string what, input logic [127:0] e, input logic [127:0] g);
		checked++;
		if (g !== e) begin
			errors++;
			$display("mismatch %s expected %h seen %h", what, e, g);
		end
	endtask

	// inputs move one nanosecond after the rising edge
	task automatic tick;
		@(posedge clk_sys);
		#1;
	endtask

	function automatic logic [7:0] oct(input logic [127:0] v, input int i);
		return v[127-8*i -: 8];
	endfunction

	// sixteen octets from a queue, zero filled past its end
	function automatic logic [127:0] blk(input logic [7:0] q[$], input int off);
		blk = '0;
		for (int i = 0; i < 16; i++) if (off + i < q.size()) blk[127-8*i -: 8] = q[off+i];
	endfunction

	// valid stays up between octets; the caller lowers it after the stream
	task automatic send(input bit is_ct, input logic [7:0] v);
		int n;
		if (is_ct) begin
			ct_valid = 1;
			ct_data  = v;
		end else begin
			ad_valid = 1;
			ad_data  = v;
		end
		for (n = 0; n < 2000; n++) begin
			@(negedge clk_sys);
			if ((is_ct ? ct_ready : ad_ready) === 1'b1) break;
		end
		if (n == 2000) begin
			errors++;
			stop_test();
		end
		tick();
	endtask

	// malformed start: refused with a fail pulse and no busy period
	task automatic bad_shape(input int m, input int c);
		bit f;
		f     = 0;
		start = 1;
		m_len = 5'(m);
		c_len = 16'(c);
		a_len = '0;
		tick();
		start = 0;
		repeat (3) begin
			@(negedge clk_sys);
			f |= (fail_pulse === 1'b1);
			chk_bit("busy", 1'b0, busy);
		end
		chk_bit("shape fail", 1'b1, f);
		tick();
	endtask

	// one frame: model builds tag and ciphertext, then verdict and blocks are compared
	task automatic run(input int m, input int a, input int p, input bit bad);
		logic [7:0]         adq[$], ptq[$], au[$], ctq[$];
		logic [NONCE_W-1:0] n;
		logic [127:0]       x, s0;
		int                 i, j, nb;
		bit                 gok, gfl, early;
		n      = NONCE_W'({$urandom, $urandom, $urandom, $urandom});
		n[7:0] = 8'(m);
		if (a > 0) au = {8'(a >> 8), 8'(a)};
		for (i = 0; i < a; i++) adq.push_back(8'($urandom));
		au = {au, adq};
		while (au.size() % 16) au.push_back(8'h00);
		for (i = 0; i < p; i++) ptq.push_back(8'($urandom));
		au = {au, ptq};
		while (au.size() % 16) au.push_back(8'h00);
		x = u_cip.enc({1'b0, a > 0, 3'(m > 0 ? (m - 2) / 2 : 0), 3'h1, n, 16'(p)});
		for (i = 0; i < au.size(); i += 16) x = u_cip.enc(x ^ blk(au, i));
		for (i = 0; i < p; i++) ctq.push_back(ptq[i] ^ oct(u_cip.enc({8'h01, n, 16'(i / 16 + 1)}), i % 16));
		s0 = u_cip.enc({8'h01, n, 16'h0000});
		for (i = 0; i < m; i++) ctq.push_back(oct(x, i) ^ oct(s0, i));
		if (bad) ctq[p] ^= 8'h01;
		start = 1;
		nonce = n;
		m_len = 5'(m);
		a_len = 64'(a);
		c_len = 16'(p + m);
		tick();
		start = 0;
		foreach (adq[i]) send(0, adq[i]);
		ad_valid = 0;
		foreach (ctq[i]) send(1, ctq[i]);
		ct_valid = 0;
		{gok, gfl, early, j} = '0;
		nb = (p + 15) / 16;
		for (i = 0; i < 3000; i++) begin
			@(negedge clk_sys);
			gok |= (ok_pulse === 1'b1);
			gfl |= (fail_pulse === 1'b1);
			early |= (!gok && pt_valid !== 1'b0) || (pt_valid !== 1'b1 && pt_data !== '0);
			if (pt_valid === 1'b1 && pt_ready === 1'b1) begin
				chk_blk("pt_data", blk(ptq, 16 * j), pt_data);
				chk_blk("pt_octets", 128'(j == nb - 1 ? p - 16 * j : 16), 128'(pt_octets));
				chk_bit("pt_last", j == nb - 1, pt_last);
				j++;
			end
			if (busy === 1'b0 && (gok || gfl)) break;
			tick();
			pt_ready = 1'($urandom % 2);
		end
		if (i == 3000) begin
			errors++;
			stop_test();
		end
		pt_ready = 0;
		chk_bit("ok_pulse", !bad, gok);
		chk_bit("fail_pulse", bad, gfl);
		chk_bit("early pt_valid", 1'b0, early);
		chk_blk("blocks", 128'(bad ? 0 : nb), 128'(j));
		tick();
	endtask

	initial begin
		void'($urandom(9299));
		repeat (12) @(posedge clk_sys);
		#1;
		reset = 0;
		bad_shape(4, 2);
		bad_shape(5, 20);
		bad_shape(2, 20);
		bad_shape(0, 257);
		for (k = 0; k <= 16; k += (k == 0 ? 4 : 2)) run(k, $urandom % 40, $urandom % 49, 0);
		run(16, 0, 256, 0);
		run(0, 0, 0, 0);
		run(10, 0, 5, 0);
		run(8, 20, 0, 1);
		run(4, 3, 17, 1);
		stop_test();
	end
endmodule
